// ### rtl/ddrcp_consts.svh
/*
  Constants of the DDR3 command pin link: clock division, init counts,
  mode register fields and burst sizes.
  Assumes inclusion by the controller and device design files.
*/
`ifndef DDRCP_CONSTS_SVH
`define DDRCP_CONSTS_SVH
// Link clock is the system clock divided by eight.
`define DDRCP_CNT_FALL_PRE 3'h3
`define DDRCP_CNT_SAMPLE 3'h7
// Link clock periods spent in reset, then with clock enable low.
`define DDRCP_RST_CK 4'h8
`define DDRCP_CKE_CK 4'h8
// Burst length field of mode register 0.
`define DDRCP_BL_LSB 0
`define DDRCP_BL_FIXED8 2'h0
`define DDRCP_BL_OTF 2'h1
`define DDRCP_BL_FIXED4 2'h2
// Termination select bits of mode register 1.
`define DDRCP_RTT_B0 2
`define DDRCP_RTT_B1 6
`define DDRCP_RTT_B2 9
// Special address bits.
`define DDRCP_AP_BIT 10
`define DDRCP_BC_BIT 12
// Beats per burst.
`define DDRCP_BEATS8 4'h8
`define DDRCP_BEATS4 4'h4
`endif

// ### rtl/ddrcp_ctrl.sv
/*
  Controller side of the DDR3 command pin link: makes the link clock,
  runs reset and clock enable startup, issues commands and bursts.
  Assumes one user command at a time and write data queued beforehand.
*/
`timescale 1ns/10ps
module ddrcp_ctrl import ddrcp_pkg::*; (
  // System clock and reset.
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // Memory pins.
  ddrcp_if.ctrl pins,
  // Command request.
  input wire logic cmd_valid_in,
  input wire logic [3:0] cmd_code_in,
  input wire logic [2:0] cmd_ba_in,
  input wire logic [15:0] cmd_addr_in,
  input wire logic cmd_odt_in,
  input wire logic cke_req_in,
  output logic cmd_ready_out,
  output logic cmd_error_out,
  output logic init_done_out,
  // Write data queue, 9 mask bits over 72 data bits.
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  input wire logic [80:0] wr_data_in,
  // Read data.
  output logic rd_valid_out,
  output logic [71:0] rd_data_out
);
  `include "ddrcp_consts.svh"
  ddrcp_ctl_t r, n; // Registered state and its next value.
  logic fall; // Link clock falls at the coming edge.
  logic pop; // Take one word from the queue.
  logic [80:0] fdata; // Queue head.
  logic [3:0] flevel; // Queue fill.
  logic [3:0] pbl; // Beats of the pending command.
  logic need_init; // Pending command needs finished setup.

  // Write data queue; its ready is the user's back-pressure.
  ddrcp_fifo #(.W(81), .D(8)) u_wq (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .in_valid_in(wr_valid_in),
    .in_ready_out(wr_ready_out),
    .in_data_in(wr_data_in),
    .out_valid_out(),
    .out_ready_in(pop),
    .out_data_out(fdata),
    .level_out(flevel)
  );

  assign fall = (r.cnt == `DDRCP_CNT_FALL_PRE);
  assign pop = fall & (r.wbeats != 4'h0);
  assign need_init = (r.pcmd == CMD_ACT) | (r.pcmd == CMD_RD) | (r.pcmd == CMD_WR);

  // Beats follow the burst mode last written to mode register 0.
  always_comb begin
    if (r.bl_mode == `DDRCP_BL_OTF) begin
      pbl = r.paddr[`DDRCP_BC_BIT] ? `DDRCP_BEATS8 : `DDRCP_BEATS4;
    end else if (r.bl_mode == `DDRCP_BL_FIXED4) begin
      pbl = `DDRCP_BEATS4;
    end else begin
      pbl = `DDRCP_BEATS8;
    end
  end

  // Next state. Pins change on the link clock's falling edge so they
  // are steady around the rising edge where the device samples.
  always_comb begin
    n = r;
    n.cnt = r.cnt + 3'h1;
    n.ck = ~n.cnt[2];
    n.dqs = n.ck; // Write strobe rises mid-beat.
    n.s1 = pins.wide_data_lines;
    n.s2 = r.s1;
    n.rd_valid = 1'b0;
    // Accept a request when idle.
    if (cmd_valid_in && r.rdy) begin
      n.pend = 1'b1;
      n.pcmd = cmd_code_in;
      n.pba = cmd_ba_in;
      n.paddr = cmd_addr_in;
      n.podt = cmd_odt_in; // Held back until the next link clock fall.
      n.err = 1'b0;
    end
    if (fall) begin
      n.cmd = CMD_DES;
      n.dq_oe = 1'b0;
      case (r.ph)
        PH_RST: begin
          // Hold reset and enable low until the clock has settled.
          n.wait_n = r.wait_n - 4'h1;
          if (r.wait_n == 4'h0) begin
            n.rst_n = 1'b1;
            n.ph = PH_CKEW;
            n.wait_n = `DDRCP_CKE_CK;
          end
        end
        PH_CKEW: begin
          n.wait_n = r.wait_n - 4'h1;
          if (r.wait_n == 4'h0) begin
            n.cke = 1'b1;
            n.ph = PH_RUN;
          end
        end
        PH_RUN: begin
          n.cke = cke_req_in;
          if (r.wbeats != 4'h0) begin
            // One beat per link clock, centred on the rising edge.
            n.dq = fdata[71:0];
            n.dm = fdata[80:72];
            n.dq_oe = 1'b1;
            n.wbeats = r.wbeats - 4'h1;
          end else if (r.pend && r.rbeats == 4'h0) begin
            if (need_init && r.mr_done != 4'hF) begin
              n.pend = 1'b0; // Access before setup is dropped.
              n.err = 1'b1;
            end else if (r.pcmd != CMD_WR || flevel >= pbl) begin
              n.pend = 1'b0;
              n.cmd = r.pcmd;
              n.ba = r.pba;
              n.addr = r.paddr;
              n.odt = r.podt;
              if (r.pcmd == CMD_MRS && !r.pba[2]) begin
                n.mr_done[r.pba[1:0]] = 1'b1;
                if (r.pba[1:0] == 2'h0) begin
                  n.bl_mode = r.paddr[`DDRCP_BL_LSB+:2];
                end
              end
              if (r.pcmd == CMD_WR) begin
                n.wbeats = pbl;
              end
              if (r.pcmd == CMD_RD) begin
                n.rbeats = pbl;
                n.rskip = 1'b1;
              end
            end
          end
        end
        default: begin
          n.ph = PH_RST;
        end
      endcase
    end
    // Read beats are caught late in each link clock period.
    if (r.cnt == `DDRCP_CNT_SAMPLE && r.rbeats != 4'h0) begin
      if (r.rskip) begin
        // The read still stands on the pins in its own period, and the
        // first beat follows one link period after the device takes it.
        n.rskip = (r.cmd == CMD_RD);
      end else begin
        n.rd_data = r.s2;
        n.rd_valid = 1'b1;
        n.rbeats = r.rbeats - 4'h1;
      end
    end
    n.rdy = (n.ph == PH_RUN) & ~n.pend & (n.wbeats == 4'h0) & (n.rbeats == 4'h0);
  end

  // Single state register.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      r <= '0;
      r.cmd <= CMD_DES;
      // Count zero is the high phase, so no short first period follows reset.
      r.ck <= 1'b1;
      r.wait_n <= `DDRCP_RST_CK;
    end else begin
      r <= n;
    end
  end

  // Pin drivers, all from flops.
  assign pins.ck = r.ck;
  assign pins.cke = r.cke;
  assign {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} = r.cmd;
  assign pins.odt = r.odt;
  assign pins.rst_n = r.rst_n;
  assign pins.ba = r.ba;
  assign pins.addr = r.addr;
  assign pins.lower_byte_write_masks = {r.dm[8], r.dm[6], r.dm[4], r.dm[2], r.dm[0]};
  assign pins.upper_byte_write_masks = {r.dm[7], r.dm[5], r.dm[3], r.dm[1]};
  assign pins.ctl_dq = r.dq;
  assign pins.ctl_dq_oe = r.dq_oe;
  assign pins.ctl_dqs = r.dqs;
  assign pins.ctl_dqs_oe = r.dq_oe;
  assign cmd_ready_out = r.rdy;
  assign cmd_error_out = r.err;
  assign init_done_out = &r.mr_done;
  assign rd_valid_out = r.rd_valid;
  assign rd_data_out = r.rd_data;
endmodule : ddrcp_ctrl

// ### rtl/ddrcp_device.sv
/*
  Memory side of the DDR3 command pin link: samples the link clock,
  decodes commands, tracks power states, termination and a small array.
  Assumes the controller end drives all command pins and the link clock.
*/
// Summary of operation
// - Termination follows registered termination input.
// - Termination applies to data pins only.
// - Termination input ignored when disabled in mode.
// - Inputs sampled at rising link clock.
// - Output strobe timed from link clock edges.
// - Clock enable gates internal circuitry and clocks.
// - Clock enable low picks power-down or refresh.
// - Self-refresh exit needs no running clock.
// - Power-down keeps clock, enable, reset, termination.
// - Self refresh keeps only enable and reset.
// - Chip select high masks every command.
// - Command decoded from four strobe pins.
// - Masked write bytes leave memory unchanged.
// - Bank inputs pick the addressed bank.
// - Bank inputs pick mode register zero-three.
// - Link reset acts asynchronously.
// - Address carries row, column, auto-precharge flag.
// - Precharge closes one bank or all.
// - Address carries mode register operation code.
// - Address bit twelve selects chopped burst.
// - Data bus is 72-bit and two-way.
// - Read strobe edge-aligned, write strobe centred.
`timescale 1ns/10ps
module ddrcp_device import ddrcp_pkg::*; (
  // System clock and reset.
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // Memory pins.
  ddrcp_if.device pins,
  // Status seen by the user.
  output logic term_data_out,
  output logic internal_clk_en_out,
  output logic cmd_buf_en_out,
  output logic clk_buf_en_out,
  output ddrcp_pwr_t power_state_out,
  output logic [7:0] open_banks_out
);
  `include "ddrcp_consts.svh"
  ddrcp_dev_t r, n; // Registered state and its next value.
  ddrcp_pins_t now; // Raw pin levels this cycle.
  logic [71:0] mem_r [16]; // Small backing array.
  logic rst_all_n; // Combined reset.
  logic rise; // Link clock rising seen in synced copy.
  logic [3:0] code; // Command code.
  logic rtt_en; // Termination enabled in mode register 1.
  logic [1:0] bl_mode; // Burst field of mode register 0.
  logic [3:0] bl; // Beats for the command now decoded.
  logic mem_we; // Write beat strobe.
  logic [3:0] widx; // Array word of the beat.
  logic [15:0] mr1; // Mode register 1 copy.

  // The link reset clears the device at once, clock or not.
  assign rst_all_n = reset_n_in & pins.rst_n;

  // Gather pins; masks interleave as lower on even bytes, upper on odd.
  always_comb begin
    now.ck = pins.ck;
    now.cke = pins.cke;
    now.cmd = {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n};
    now.odt = pins.odt;
    now.ba = pins.ba;
    now.addr = pins.addr;
    now.dq = pins.wide_data_lines;
    for (int j = 0; j < 9; j++) begin
      if (j % 2 == 1) begin
        now.dm[j] = pins.upper_byte_write_masks[j / 2];
      end else begin
        now.dm[j] = pins.lower_byte_write_masks[j / 2];
      end
    end
  end

  // Decoded helpers from the synced pin copy and mode registers.
  assign rise = r.s2.ck & ~r.ck_d;
  assign code = r.s2.cmd;
  assign mr1 = r.mr[31:16];
  assign rtt_en = mr1[`DDRCP_RTT_B0] | mr1[`DDRCP_RTT_B1] | mr1[`DDRCP_RTT_B2];
  assign bl_mode = r.mr[`DDRCP_BL_LSB+:2];
  assign widx = {r.ba[0], r.col};
  assign mem_we = rise & (r.beats != 4'h0) & ~r.rd;

  // Burst size: on-the-fly mode reads address bit 12, else fixed.
  always_comb begin
    if (bl_mode == `DDRCP_BL_OTF) begin
      bl = r.s2.addr[`DDRCP_BC_BIT] ? `DDRCP_BEATS8 : `DDRCP_BEATS4;
    end else if (bl_mode == `DDRCP_BL_FIXED4) begin
      bl = `DDRCP_BEATS4;
    end else begin
      bl = `DDRCP_BEATS8;
    end
  end

  // Next state. Every pin but the link reset passes two flops before anything reads it.
  always_comb begin
    n = r;
    n.s1 = now;
    n.s2 = r.s1;
    n.ck_d = r.s2.ck;
    if (r.pwr == PWR_SREF) begin
      // Exit is taken from the synced enable level alone, so it works
      // while the link clock is stopped.
      if (r.s2.cke) begin
        n.pwr = PWR_ON;
        n.cke_q = 1'b1;
      end
    end else if (rise) begin
      n.cke_q = r.s2.cke;
      // Burst beats run one link clock after the command.
      if (r.beats != 4'h0) begin
        n.beats = r.beats - 4'h1;
        n.col = r.col + 3'h1;
        if (r.rd) begin
          // Data and strobe change together on the clock edge.
          n.dq = mem_r[widx];
          n.dq_oe = 1'b1;
          n.dqs = ~r.dqs;
        end
      end else begin
        n.dq_oe = 1'b0;
        n.dqs = 1'b0;
      end
      if (r.pwr == PWR_ON) begin
        // Commands count only while enable was high and select low.
        if (r.cke_q && !code[3]) begin
          case (code)
            CMD_MRS: begin
              if (!r.s2.ba[2]) begin
                n.mr[{r.s2.ba[1:0], 4'h0}+:16] = r.s2.addr;
              end
            end
            CMD_ACT: begin
              n.open[r.s2.ba] = 1'b1;
            end
            CMD_PRE: begin
              if (r.s2.addr[`DDRCP_AP_BIT]) begin
                n.open = 8'h00;
              end else begin
                n.open[r.s2.ba] = 1'b0;
              end
            end
            CMD_RD, CMD_WR: begin
              n.beats = bl;
              n.rd = (code == CMD_RD);
              n.ba = r.s2.ba;
              n.col = r.s2.addr[2:0];
              if (r.s2.addr[`DDRCP_AP_BIT]) begin
                n.open[r.s2.ba] = 1'b0;
              end
            end
            default: begin
              // Refresh, calibration and no-operation change nothing here.
            end
          endcase
        end
        // Falling enable picks the low power state.
        if (r.cke_q && !r.s2.cke) begin
          if (!code[3] && code == CMD_REF) begin
            n.pwr = PWR_SREF;
          end else if (n.open == 8'h00) begin
            n.pwr = PWR_PPD;
          end else begin
            n.pwr = PWR_APD;
          end
          n.beats = 4'h0;
        end
      end else if (r.s2.cke) begin
        // Power-down exit is synchronous to the link clock.
        n.pwr = PWR_ON;
      end
      // Termination follows the input only while mode allows it.
      n.term = r.s2.odt & rtt_en;
    end
    if (n.pwr == PWR_SREF) begin
      n.term = 1'b0;
      n.dq_oe = 1'b0;
    end
    // Input buffer enables per power state.
    n.cmd_en = (n.pwr == PWR_ON);
    n.ck_en = (n.pwr != PWR_SREF);
  end

  // Single state register.
  always_ff @(posedge sys_clk_in or negedge rst_all_n) begin
    if (!rst_all_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // Array writes keep every byte whose mask bit was high.
  always_ff @(posedge sys_clk_in) begin
    if (mem_we) begin
      for (int j = 0; j < 9; j++) begin
        if (!r.s2.dm[j]) begin
          mem_r[widx][j*8+:8] <= r.s2.dq[j*8+:8];
        end
      end
    end
  end

  // Pin drivers and status, all from flops.
  assign pins.dev_dq = r.dq;
  assign pins.dev_dq_oe = r.dq_oe;
  assign pins.dev_dqs = r.dqs;
  assign pins.dev_dqs_oe = r.dq_oe;
  // Only the data pins carry termination; command pins never do.
  assign term_data_out = r.term;
  assign internal_clk_en_out = r.cke_q;
  assign cmd_buf_en_out = r.cmd_en;
  assign clk_buf_en_out = r.ck_en;
  assign power_state_out = r.pwr;
  assign open_banks_out = r.open;
endmodule : ddrcp_device

// ### rtl/ddrcp_fifo.sv
/*
  Write data FIFO with valid and ready on both sides and a fill level.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/10ps
module ddrcp_fifo #(
  parameter int W = 81,
  parameter int D = 8
) (
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // Fill side.
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [W-1:0] in_data_in,
  // Drain side.
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [W-1:0] out_data_out,
  output logic [$clog2(D):0] level_out
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_r [D]; // Storage words.
  logic [AW-1:0] wp_r, rp_r; // Write and read pointers.
  logic [AW:0] cnt_r; // Words held.
  logic push, pop;
  // Full and empty come straight from the count.
  assign push = in_valid_in & (cnt_r != AW'(0) + (AW+1)'(D));
  assign pop = out_ready_in & (cnt_r != '0);
  assign in_ready_out = (cnt_r != (AW+1)'(D));
  assign out_valid_out = (cnt_r != '0);
  assign out_data_out = mem_r[rp_r];
  assign level_out = cnt_r;
  // Pointers wrap naturally because depth is a power of two.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_r + AW'(push);
      rp_r <= rp_r + AW'(pop);
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  // Storage has no reset; it is never read while empty.
  always_ff @(posedge sys_clk_in) begin
    if (push) begin
      mem_r[wp_r] <= in_data_in;
    end
  end
endmodule : ddrcp_fifo

// ### rtl/ddrcp_if.sv
/*
  Pin bundle between controller and device, with wire resolution.
  Assumes at most one end enables its drivers at a time.
*/
`timescale 1ns/10ps
interface ddrcp_if;
  // Controller driven lines.
  logic ck, cke, cs_n, ras_n, cas_n, we_n, odt, rst_n;
  logic [2:0] ba;
  logic [15:0] addr;
  logic [4:0] lower_byte_write_masks;
  logic [3:0] upper_byte_write_masks;
  // Two-way data and strobe, one set per end.
  logic [71:0] ctl_dq, dev_dq;
  logic ctl_dq_oe, dev_dq_oe, ctl_dqs, dev_dqs, ctl_dqs_oe, dev_dqs_oe;
  // Resolved wire levels; an undriven bus reads as zero.
  logic [71:0] wide_data_lines;
  logic data_strobe;
  assign wide_data_lines = ctl_dq_oe ? ctl_dq : (dev_dq_oe ? dev_dq : 72'h0);
  assign data_strobe = ctl_dqs_oe ? ctl_dqs : (dev_dqs_oe ? dev_dqs : 1'b0);
  modport ctrl (output ck, cke, cs_n, ras_n, cas_n, we_n, odt, rst_n, ba, addr,
    lower_byte_write_masks, upper_byte_write_masks, ctl_dq, ctl_dq_oe, ctl_dqs,
    ctl_dqs_oe, input wide_data_lines, data_strobe);
  modport device (input ck, cke, cs_n, ras_n, cas_n, we_n, odt, rst_n, ba, addr,
    lower_byte_write_masks, upper_byte_write_masks, wide_data_lines, data_strobe,
    output dev_dq, dev_dq_oe, dev_dqs, dev_dqs_oe);
endinterface : ddrcp_if

// ### rtl/ddrcp_pkg.sv
/*
  Types shared by both ends of the DDR3 command pin link.
  Assumes the constants header sits beside it.
*/
package ddrcp_pkg;
  // Command code {cs_n, ras_n, cas_n, we_n}.
  typedef enum logic [3:0] {
    CMD_MRS = 4'h0, CMD_REF = 4'h1, CMD_PRE = 4'h2, CMD_ACT = 4'h3,
    CMD_WR = 4'h4, CMD_RD = 4'h5, CMD_ZQ = 4'h6, CMD_NOP = 4'h7,
    CMD_DES = 4'h8
  } ddrcp_cmd_t;
  // Device power states.
  typedef enum logic [1:0] {PWR_ON, PWR_PPD, PWR_APD, PWR_SREF} ddrcp_pwr_t;
  // Controller phases.
  typedef enum logic [1:0] {PH_RST, PH_CKEW, PH_RUN} ddrcp_ph_t;
  // Pins sampled by the device.
  typedef struct packed {
    logic ck;
    logic cke;
    logic [3:0] cmd;
    logic odt;
    logic [2:0] ba;
    logic [15:0] addr;
    logic [71:0] dq;
    logic [8:0] dm;
  } ddrcp_pins_t;
  // Whole state of the device end.
  typedef struct packed {
    ddrcp_pins_t s1;
    ddrcp_pins_t s2;
    logic ck_d;
    logic cke_q;
    ddrcp_pwr_t pwr;
    logic [7:0] open;
    logic [63:0] mr;
    logic [3:0] beats;
    logic rd;
    logic [2:0] ba;
    logic [2:0] col;
    logic [71:0] dq;
    logic dq_oe;
    logic dqs;
    logic term;
    logic cmd_en;
    logic ck_en;
  } ddrcp_dev_t;
  // Whole state of the controller end.
  typedef struct packed {
    logic [2:0] cnt;
    logic ck;
    logic rst_n;
    logic cke;
    ddrcp_ph_t ph;
    logic [3:0] wait_n;
    logic [3:0] mr_done;
    logic [1:0] bl_mode;
    logic [3:0] cmd;
    logic [2:0] ba;
    logic [15:0] addr;
    logic odt;
    logic podt;
    logic pend;
    logic [3:0] pcmd;
    logic [2:0] pba;
    logic [15:0] paddr;
    logic [3:0] wbeats;
    logic [3:0] rbeats;
    logic rskip;
    logic [71:0] dq;
    logic [8:0] dm;
    logic dq_oe;
    logic dqs;
    logic [71:0] s1;
    logic [71:0] s2;
    logic [71:0] rd_data;
    logic rd_valid;
    logic rdy;
    logic err;
  } ddrcp_ctl_t;
endpackage : ddrcp_pkg

// ### tb/ddr3_command_pin_interface_tb.sv
/*
  Self-checking bench: controller and device joined by the interface.
  Assumes the package and both ends are compiled first.
*/
`timescale 1ns/10ps
module ddr3_command_pin_interface_tb import ddrcp_pkg::*; ;
  // Stimulus, all given at time zero.
  logic sys_clk_in = 1'h0, reset_n_in = 1'h0, cmd_valid_in = 1'h0, cmd_odt_in = 1'h0;
  logic cke_req_in = 1'h1, wr_valid_in = 1'h0;
  logic [3:0] cmd_code_in = 4'h7;
  logic [2:0] cmd_ba_in = 3'h0;
  logic [15:0] cmd_addr_in = 16'h0;
  logic [80:0] wr_data_in = 81'h0;
  // Observed outputs.
  logic cmd_ready_out, cmd_error_out, init_done_out, wr_ready_out, rd_valid_out;
  logic term_data_out, internal_clk_en_out, cmd_buf_en_out, clk_buf_en_out;
  logic [71:0] rd_data_out;
  ddrcp_pwr_t power_state_out;
  logic [7:0] open_banks_out;
  // Counters and captured read beats.
  int n_fail = 0, num_checks = 0, cyc = 0, nb = 0;
  logic [71:0] got [8];
  logic [71:0] e;
  ddrcp_if ddrcp_if_i ();
  ddrcp_ctrl ddrcp_ctrl_i (.sys_clk_in, .reset_n_in, .pins(ddrcp_if_i), .cmd_valid_in, .cmd_code_in,
    .cmd_ba_in, .cmd_addr_in, .cmd_odt_in, .cke_req_in, .cmd_ready_out, .cmd_error_out, .init_done_out,
    .wr_valid_in, .wr_ready_out, .wr_data_in, .rd_valid_out, .rd_data_out);
  ddrcp_device ddrcp_device_i (.sys_clk_in, .reset_n_in, .pins(ddrcp_if_i), .term_data_out,
    .internal_clk_en_out, .cmd_buf_en_out, .clk_buf_en_out, .power_state_out, .open_banks_out);
  ddrcp_props ddrcp_props_i (.sys_clk_in, .reset_n_in, .ck(ddrcp_if_i.ck), .cke(ddrcp_if_i.cke),
    .cs_n(ddrcp_if_i.cs_n), .ras_n(ddrcp_if_i.ras_n), .cas_n(ddrcp_if_i.cas_n), .we_n(ddrcp_if_i.we_n),
    .odt(ddrcp_if_i.odt), .rst_n(ddrcp_if_i.rst_n), .ba(ddrcp_if_i.ba), .addr(ddrcp_if_i.addr),
    .ctl_dq(ddrcp_if_i.ctl_dq), .ctl_dq_oe(ddrcp_if_i.ctl_dq_oe), .dev_dq_oe(ddrcp_if_i.dev_dq_oe));
  // Compare one result and count it.
  task automatic chk(input string nm, input logic [71:0] ex, input logic [71:0] g);
    num_checks++;
    if (g !== ex) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, ex, g);
    end
  endtask : chk
  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  task automatic waitc(input int k);
    repeat (k) @(negedge sys_clk_in);
  endtask : waitc
  // One command; waits long enough for any burst, capturing read beats.
  task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [15:0] a, input logic o);
    int n = 0;
    do begin
      @(negedge sys_clk_in);
      n++;
    end while (cmd_ready_out !== 1'h1 && n < 4000);
    if (n >= 4000) chk("ready", 72'h1, 72'h0);
    @(posedge sys_clk_in);
    {cmd_code_in, cmd_ba_in, cmd_addr_in, cmd_odt_in, cmd_valid_in} <= {c, b, a, o, 1'h1};
    @(posedge sys_clk_in);
    cmd_valid_in <= 1'h0;
    nb = 0;
    repeat (200) begin
      @(negedge sys_clk_in);
      if (rd_valid_out === 1'h1) begin
        if (nb < 8) got[nb] = rd_data_out;
        nb++;
      end
    end
  endtask : issue
  // Push words into the queue until it refuses; eight should fit.
  task automatic fill(input logic [3:0] b, input logic [8:0] m);
    int n = 0;
    @(posedge sys_clk_in);
    wr_valid_in <= 1'h1;
    wr_data_in <= {m, {9{b, 4'h0}}};
    repeat (12) begin
      @(negedge sys_clk_in);
      if (wr_ready_out === 1'h1) n++;
      @(posedge sys_clk_in);
      wr_data_in <= {m, {9{b, n[3:0]}}};
    end
    wr_valid_in <= 1'h0;
    chk("fill", 72'h8, n);
  endtask : fill
  task automatic t_init;
    issue(CMD_ACT, 3'h0, 16'h0000, 1'h0);
    chk("early", 72'h1, cmd_error_out);
    chk("banks", 72'h0, open_banks_out);
    // Mode 0 selects on-the-fly chop, mode 1 enables termination.
    for (int i = 0; i < 4; i++) issue(CMD_MRS, i[2:0], (i == 0) ? 16'h1 : (i == 1) ? 16'h4 : 16'h0, 1'h0);
    chk("init", 72'h1, init_done_out);
    chk("err clr", 72'h0, cmd_error_out);
  endtask : t_init
  task automatic t_odt;
    issue(CMD_NOP, 3'h0, 16'h0000, 1'h1);
    chk("term on", 72'h1, term_data_out);
    issue(CMD_NOP, 3'h0, 16'h0000, 1'h0);
    chk("term off", 72'h0, term_data_out);
    issue(CMD_MRS, 3'h1, 16'h0000, 1'h0);
    issue(CMD_NOP, 3'h0, 16'h0000, 1'h1);
    chk("term dis", 72'h0, term_data_out);
    issue(CMD_MRS, 3'h1, 16'h0004, 1'h0);
  endtask : t_odt
  task automatic t_banks;
    issue(CMD_ACT, 3'h5, 16'h0123, 1'h0);
    issue(CMD_ACT, 3'h2, 16'h0040, 1'h0);
    chk("act", 72'h24, open_banks_out);
    issue(CMD_PRE, 3'h5, 16'h0000, 1'h0);
    chk("pre one", 72'h04, open_banks_out);
    issue(CMD_ACT, 3'h7, 16'h0001, 1'h0);
    issue(CMD_PRE, 3'h0, 16'h0400, 1'h0);
    chk("pre all", 72'h0, open_banks_out);
  endtask : t_banks
  task automatic t_power;
    issue(CMD_ACT, 3'h1, 16'h0000, 1'h0);
    @(posedge sys_clk_in) cke_req_in <= 1'h0;
    waitc(40);
    chk("apd", PWR_APD, power_state_out);
    chk("clk en", 72'h0, internal_clk_en_out);
    chk("clk buf", 72'h1, clk_buf_en_out);
    chk("cmd buf", 72'h0, cmd_buf_en_out);
    @(posedge sys_clk_in) cke_req_in <= 1'h1;
    waitc(40);
    chk("exit", PWR_ON, power_state_out);
    issue(CMD_PRE, 3'h0, 16'h0400, 1'h0);
    @(posedge sys_clk_in) cke_req_in <= 1'h0;
    waitc(40);
    chk("ppd", PWR_PPD, power_state_out);
    @(posedge sys_clk_in) cke_req_in <= 1'h1;
    waitc(40);
  endtask : t_power
  // Refresh on the same link edge as falling enable enters self refresh.
  task automatic t_sref;
    @(posedge ddrcp_if_i.ck);
    @(posedge sys_clk_in);
    {cmd_code_in, cmd_valid_in, cke_req_in} <= {CMD_REF, 1'h1, 1'h0};
    @(posedge sys_clk_in);
    cmd_valid_in <= 1'h0;
    waitc(40);
    chk("sref", PWR_SREF, power_state_out);
    chk("sref clk buf", 72'h0, clk_buf_en_out);
    @(posedge sys_clk_in) cke_req_in <= 1'h1;
    waitc(40);
    chk("sref exit", PWR_ON, power_state_out);
  endtask : t_sref
  // Masked second write must keep odd bytes of the first.
  task automatic t_wr_rd;
    issue(CMD_ACT, 3'h0, 16'h0000, 1'h0);
    fill(4'hA, 9'h000);
    issue(CMD_WR, 3'h0, 16'h1000, 1'h0);
    fill(4'hB, 9'h0AA);
    issue(CMD_WR, 3'h0, 16'h1000, 1'h0);
    issue(CMD_RD, 3'h0, 16'h1000, 1'h0);
    chk("beats8", 72'h8, nb);
    for (int i = 0; i < 8; i++) begin
      for (int j = 0; j < 9; j++) e[8*j+:8] = {(j % 2 == 1) ? 4'hA : 4'hB, i[3:0]};
      chk("rd data", e, got[i]);
    end
    issue(CMD_RD, 3'h0, 16'h0000, 1'h0);
    chk("beats4", 72'h4, nb);
  endtask : t_wr_rd
  // Clock, reset, sequence and hang guard.
  initial forever #20 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      summarize();
    end
  end
  initial begin
    repeat (6) @(posedge sys_clk_in);
    reset_n_in <= 1'h1;
    t_init();
    t_odt();
    t_banks();
    t_power();
    t_sref();
    t_wr_rd();
    summarize();
  end
endmodule : ddr3_command_pin_interface_tb

// ### tb/ddrcp_props.sv
/*
  Checker of the link pins between the two ends.
  Assumes instantiation beside the interface, on the system clock.
*/
`timescale 1ns/10ps
module ddrcp_props (
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // Link pins.
  input wire logic ck,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic odt,
  input wire logic rst_n,
  input wire logic [2:0] ba,
  input wire logic [15:0] addr,
  input wire logic [71:0] ctl_dq,
  input wire logic ctl_dq_oe,
  input wire logic dev_dq_oe
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  // The link clock is four cycles high and four low.
  a_ck_divide: assert property ($rose(ck) |-> ck [*4] ##1 !ck [*4] ##1 ck)
    else $error("link clock period wrong");
  // A command stands for one link period, then deselect.
  a_cmd_width: assert property ($fell(cs_n) |-> !cs_n [*8] ##1 cs_n)
    else $error("command width wrong");
  // Pins only move at the falling link edge.
  a_cmd_stable: assert property ($rose(ck) |-> $stable({cs_n, ras_n, cas_n, we_n, ba, addr}))
    else $error("command pins moved at rise");
  a_cke_stable: assert property ($rose(ck) |-> $stable({cke, odt}))
    else $error("cke or odt moved at rise");
  // Two drivers on the data bus would fight.
  a_one_driver: assert property (!(ctl_dq_oe && dev_dq_oe))
    else $error("both ends drive data");
  a_wdata_centre: assert property ($rose(ck) && ctl_dq_oe |-> $stable(ctl_dq))
    else $error("write data moved at strobe");
  a_reset_idle: assert property (!rst_n |-> cs_n && !cke)
    else $error("pins active in reset");
  a_reset_hold: assert property ($rose(rst_n) |-> !cke [*8])
    else $error("cke rose too soon");
endmodule : ddrcp_props
